// ===== sesl_defines.vh
// Constants for the secure element serial link
`ifndef SESL_DEFINES_VH
`define SESL_DEFINES_VH
// Byte width of a serial word
`define SESL_WORD_BITS 8
// Reported maximum transfer unit, bytes
`define SESL_MTU_BYTES 16'h0100
// Master clock divider: half period is this value plus one core cycles (40 MHz / 22, about 1.82 MHz)
`define SESL_HALF_DIV 8'h0a
// Command byte a master sends to poll a target
`define SESL_POLL_BYTE 8'h00
// Core clock rate in kHz and least serial rate in kbit/s
`define SESL_CLK_KHZ 40000
`define SESL_MIN_KBPS 1000
`endif

// ===== sesl_sync.v
// Two flip-flop synchroniser for link pins
`timescale 1ns/1ps
`default_nettype none
module sesl_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Asynchronous level in, synchronised level out
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;
  // ==========================================================
  // Two stages; first stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule // sesl_sync
`default_nettype wire

// ===== sesl_link.v
// Serial link between the secure platform and a host terminal
`timescale 1ns/1ps
`default_nettype none
`include "sesl_defines.vh"
module sesl_link #(
  parameter WORD_BITS = `SESL_WORD_BITS,
  parameter [15:0] MTU_BYTES = `SESL_MTU_BYTES,
  parameter [7:0] HALF_DIV = `SESL_HALF_DIV
) (
  // Core clock and reset
  input wire CLOCK,
  input wire RESET_N,
  // Role and link control
  input wire MASTER_MODE,
  input wire LINK_ENABLE,
  input wire SUSPEND,
  input wire START_XFER,
  // Serial pins, inputs (MISO_IN for the master role, the rest for the target role)
  input wire SCLK_IN,
  input wire CS_N_IN,
  input wire MOSI_IN,
  input wire MISO_IN,
  // Serial pins, outputs with low-active enables, and attention output
  output wire SCLK_OUT,
  output wire SCLK_OE_N,
  output wire CS_N_OUT,
  output wire CS_N_OE_N,
  output wire SDO_OUT,
  output wire SDO_OE_N,
  output wire ATTN_N,
  // Transmit stream from upper layer
  input wire [WORD_BITS-1:0] TX_DATA,
  input wire TX_VALID,
  output wire TX_READY,
  // Receive stream to upper layer
  output wire [WORD_BITS-1:0] RX_DATA,
  output wire RX_VALID,
  input wire RX_READY,
  // Status and events
  output wire [15:0] MTU,
  output wire LINK_ACTIVE,
  output wire EVT_SELECT,
  output wire EVT_DESELECT,
  output wire RX_OVERRUN
);
  // Most cycles per serial bit, reached at the minimum rate
  localparam MIN_BIT_CYC = `SESL_CLK_KHZ / `SESL_MIN_KBPS;
  // States, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_XFER = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  wire [2:0] pin_sync;
  wire sclk_s;
  wire csn_s;
  wire din_s;
  reg sclk_d_ff;
  reg csn_d_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [WORD_BITS-1:0] sh_ff;
  reg [WORD_BITS-1:0] nxt_sh;
  reg [3:0] cnt_ff;
  reg [3:0] nxt_cnt;
  reg [7:0] div_ff;
  reg [7:0] nxt_div;
  reg mclk_ff;
  reg nxt_mclk;
  reg [WORD_BITS-1:0] txb_ff;
  reg txb_v_ff;
  reg [WORD_BITS-1:0] rx_ff;
  reg rx_v_ff;
  reg ovr_ff;
  reg sdo_ff;
  reg sel_ev_ff;
  reg desel_ev_ff;
  reg tx_taken_ff;
  wire run;
  wire rise;
  wire fall;
  wire sel;
  wire done;

  // ==========================================================
  // Pin synchronisers
  sesl_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .din({SCLK_IN, ~CS_N_IN, (MASTER_MODE ? MISO_IN : MOSI_IN)}),
    .dout(pin_sync)
  );
  assign sclk_s = pin_sync[2];
  // Select travels inverted so a reset synchroniser reads as deselected
  assign csn_s = ~pin_sync[1];
  assign din_s = pin_sync[0];

  // Link may start a word only when enabled and not suspended
  assign run = LINK_ENABLE & ~SUSPEND;
  // Select seen from the bus (target) or from own master state
  assign sel = MASTER_MODE ? (state_ff == ST_XFER) : (~csn_s & run);

  // Edges of the serial clock in either role
  function edge_det;
    input now;
    input was;
    input up;
    begin
      edge_det = up ? (now & ~was) : (~now & was);
    end
  endfunction
  // Master edges come from registered state only, no loop through nxt_
  assign rise = MASTER_MODE ?
                ((state_ff == ST_XFER) & ~mclk_ff & (div_ff == 8'h00)) :
                edge_det(sclk_s, sclk_d_ff, 1'b1);
  assign fall = MASTER_MODE ?
                ((state_ff == ST_XFER) & mclk_ff & (div_ff == 8'h00)) :
                edge_det(sclk_s, sclk_d_ff, 1'b0);
  assign done = (state_ff == ST_XFER) & rise &
                (cnt_ff == WORD_BITS - 1);

  // ==========================================================
  // Next state and shift logic
  always @* begin
    nxt_state = state_ff;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_div = div_ff;
    nxt_mclk = mclk_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_mclk = 1'b0;
        nxt_cnt = 4'h0;
        nxt_sh = txb_v_ff ? txb_ff : `SESL_POLL_BYTE;
        // Master starts on request, on target attention or with a held byte
        if (run & MASTER_MODE & ~rx_v_ff &
            (START_XFER | ~din_s | txb_v_ff)) begin
          nxt_state = ST_XFER;
          nxt_div = HALF_DIV;
        end else if (run & ~MASTER_MODE & ~csn_s) begin
          nxt_state = ST_XFER;
        end
      end
      ST_XFER: begin
        // Master clock divider, idle low
        if (MASTER_MODE) begin
          if (div_ff == 8'h00) begin
            nxt_div = HALF_DIV;
          end else begin
            nxt_div = div_ff - 8'h01;
          end
          if (div_ff == 8'h00) begin
            nxt_mclk = ~mclk_ff;
          end
        end
        // One bit each way per clock period
        if (rise) begin
          nxt_sh = {sh_ff[WORD_BITS-2:0], din_s};
          nxt_cnt = cnt_ff + 4'h1;
        end
        if (done) begin
          nxt_state = ST_DONE;
        end else if (~MASTER_MODE & (csn_s | ~run)) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DONE: begin
        nxt_mclk = 1'b0;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_IDLE;
      sh_ff <= {WORD_BITS{1'b0}};
      cnt_ff <= 4'h0;
      div_ff <= 8'h00;
      mclk_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      csn_d_ff <= 1'b1;
      sdo_ff <= 1'b0;
      sel_ev_ff <= 1'b0;
      desel_ev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      div_ff <= nxt_div;
      mclk_ff <= nxt_mclk;
      sclk_d_ff <= sclk_s;
      csn_d_ff <= csn_s;
      // Drive output bit after falling edge or at word start
      if (state_ff == ST_IDLE) begin
        sdo_ff <= nxt_sh[WORD_BITS-1];
      end else if (fall) begin
        sdo_ff <= sh_ff[WORD_BITS-1];
      end
      // Host select and deselect events
      sel_ev_ff <= ~MASTER_MODE & csn_d_ff & ~csn_s;
      desel_ev_ff <= ~MASTER_MODE & ~csn_d_ff & csn_s;
    end
  end

  // ==========================================================
  // Transmit holding byte and receive delivery
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      txb_ff <= {WORD_BITS{1'b0}};
      txb_v_ff <= 1'b0;
      rx_ff <= {WORD_BITS{1'b0}};
      rx_v_ff <= 1'b0;
      ovr_ff <= 1'b0;
      tx_taken_ff <= 1'b0;
    end else begin
      // Remember whether the running word carries the held byte
      if (state_ff == ST_IDLE) begin
        tx_taken_ff <= txb_v_ff;
      end
      if (TX_VALID & ~txb_v_ff) begin
        txb_ff <= TX_DATA;
        txb_v_ff <= 1'b1;
      end else if ((state_ff == ST_DONE) & tx_taken_ff) begin
        txb_v_ff <= 1'b0;
      end
      // Whole bytes only, in order; a full buffer flags overrun
      if (state_ff == ST_DONE) begin
        if (rx_v_ff & ~RX_READY) begin
          ovr_ff <= 1'b1;
        end else begin
          rx_ff <= sh_ff;
          rx_v_ff <= 1'b1;
        end
      end else if (RX_READY) begin
        rx_v_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign TX_READY = ~txb_v_ff;
  assign RX_DATA = rx_ff;
  assign RX_VALID = rx_v_ff;
  assign RX_OVERRUN = ovr_ff;
  assign MTU = MTU_BYTES;
  assign LINK_ACTIVE = sel;
  assign EVT_SELECT = sel_ev_ff;
  assign EVT_DESELECT = desel_ev_ff;
  assign SCLK_OUT = mclk_ff;
  assign SCLK_OE_N = ~(MASTER_MODE & run);
  assign CS_N_OUT = ~(MASTER_MODE & (state_ff != ST_IDLE));
  assign CS_N_OE_N = ~(MASTER_MODE & run);
  assign SDO_OUT = sdo_ff;
  assign SDO_OE_N = ~(sel & (state_ff != ST_IDLE));
  // Target asks for service while it holds data
  assign ATTN_N = ~(~MASTER_MODE & run & txb_v_ff);
  // Divider bit time must not exceed the least-rate bit time
  wire unused_ok = (2 * (HALF_DIV + 1) <= MIN_BIT_CYC);
endmodule // sesl_link
`default_nettype wire

// ===== sesl_link_asserts.sv
// Assertion checker for the secure element serial link
`timescale 1ns/1ps
`default_nettype none
module sesl_link_asserts #(
  parameter WORD_BITS = 8,
  parameter [15:0] MTU_BYTES = 16'h0100
) (
  // Core clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Control and pins in
  input wire logic MASTER_MODE,
  input wire logic LINK_ENABLE,
  input wire logic SUSPEND,
  input wire logic CS_N_IN,
  // Outputs watched, and the RX_READY input
  input wire logic SCLK_OUT,
  input wire logic SCLK_OE_N,
  input wire logic CS_N_OUT,
  input wire logic CS_N_OE_N,
  input wire logic SDO_OE_N,
  input wire logic [WORD_BITS-1:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic [15:0] MTU,
  input wire logic EVT_SELECT,
  input wire logic RX_OVERRUN
);
  // ====
  // Properties
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // Target role running
  wire tgt = !MASTER_MODE && LINK_ENABLE && !SUSPEND;
  sequence s_sel; ##[1:5] EVT_SELECT; endsequence
  property p_no_drive; !MASTER_MODE [*2] |-> SCLK_OE_N && CS_N_OE_N; endproperty
  property p_cs_gate; (!MASTER_MODE && CS_N_IN) [*6] |-> SDO_OE_N; endproperty
  property p_mtu; MTU == MTU_BYTES; endproperty
  property p_rx_hold;
    RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA);
  endproperty
  property p_sel; tgt && $fell(CS_N_IN) |-> s_sel; endproperty
  property p_ovr; RX_OVERRUN |=> RX_OVERRUN; endproperty
  property p_idle_low; MASTER_MODE && CS_N_OUT |-> !SCLK_OUT; endproperty
  property p_susp; SUSPEND [*8] |-> !$rose(RX_VALID); endproperty
  a_no_drive: assert property (p_no_drive) else $error("target drives");
  a_cs_gate: assert property (p_cs_gate) else $error("sdo unselected");
  a_mtu: assert property (p_mtu) else $error("mtu value");
  a_rx_hold: assert property (p_rx_hold) else $error("rx not held");
  a_sel: assert property (p_sel) else $error("no select event");
  a_ovr: assert property (p_ovr) else $error("overrun cleared");
  a_idle_low: assert property (p_idle_low) else $error("clock idle");
  a_susp: assert property (p_susp) else $error("rx in suspend");
endmodule // sesl_link_asserts
bind sesl_link sesl_link_asserts #(.WORD_BITS(WORD_BITS),
  .MTU_BYTES(MTU_BYTES)) i_sesl_link_asserts (.CLOCK, .RESET_N,
  .MASTER_MODE, .LINK_ENABLE, .SUSPEND, .CS_N_IN, .SCLK_OUT, .SCLK_OE_N,
  .CS_N_OUT, .CS_N_OE_N, .SDO_OE_N, .RX_DATA, .RX_VALID, .RX_READY, .MTU,
  .EVT_SELECT, .RX_OVERRUN);
`default_nettype wire

// ===== sesl_host_model.sv
// Host terminal model: serial bus master in mode 0
`timescale 1ns/1ps
`default_nettype none
module sesl_host_model (
  // Serial pins toward the platform
  output var logic sclk,
  output var logic cs_n,
  output var logic mosi,
  input wire logic miso
);
  // ====
  // Idle bus: clock low and still, select high
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One byte each way, msb first, 200 ns per bit
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    mosi = tx[7];
    cs_n = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      rx[i] = miso;
      #100;
      sclk = 1'b0;
      mosi = (i > 0) ? tx[i - 1] : ~mosi;
      #100;
    end
    cs_n = 1'b1;
    #400;
  endtask
endmodule // sesl_host_model
`default_nettype wire

// ===== sesl_link_test.sv
// Self-checking bench for the secure element serial link
`timescale 1ns/1ps
`default_nettype none
`include "sesl_defines.vh"
module sesl_link_test;
  // ====
  // Signals and design
  logic clock = 0, reset_n = 0, mst = 0, en = 0, susp = 0, start = 0;
  logic txv = 0, rxr = 0, miso_in = 1, sdo_last = 0, sq = 0;
  logic [7:0] txd = 0, r;
  logic [15:0] sel_n = 0, dsel_n = 0, rises = 0, r0;
  wire sclk, cs_n, mosi, sclk_o, sclk_oe_n, cs_o, cs_oe_n, sdo, sdo_oe_n;
  wire attn_n, txr, rxv, ovr, esel, dsel, lact;
  wire [7:0] rxd;
  wire [15:0] mtu;
  int fail_count = 0, tests_run = 0;
  // Released line shows the inverse of its last value
  wire miso = sdo_oe_n ? ~sdo_last : sdo;
  always #12.5 clock = ~clock;
  // Pin history and event counts
  always @(posedge clock) begin
    if (!sdo_oe_n) sdo_last <= sdo;
    sq <= sclk_o;
    sel_n <= sel_n + esel;
    dsel_n <= dsel_n + dsel;
    if (sclk_o && !sq) rises <= rises + 1;
  end
  sesl_link i_sesl_link (.CLOCK(clock), .RESET_N(reset_n), .MASTER_MODE(mst),
    .LINK_ENABLE(en), .SUSPEND(susp), .START_XFER(start), .SCLK_IN(sclk),
    .CS_N_IN(cs_n), .MOSI_IN(mosi), .MISO_IN(miso_in), .SCLK_OUT(sclk_o),
    .SCLK_OE_N(sclk_oe_n), .CS_N_OUT(cs_o), .CS_N_OE_N(cs_oe_n),
    .SDO_OUT(sdo), .SDO_OE_N(sdo_oe_n), .ATTN_N(attn_n), .TX_DATA(txd),
    .TX_VALID(txv), .TX_READY(txr), .RX_DATA(rxd), .RX_VALID(rxv),
    .RX_READY(rxr), .MTU(mtu), .LINK_ACTIVE(lact), .EVT_SELECT(esel),
    .EVT_DESELECT(dsel), .RX_OVERRUN(ovr));
  sesl_host_model i_sesl_host_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso));
  // ====
  // Shared tasks
  task chk(input logic [15:0] s, e, input string m);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task push(input logic [7:0] d);
    for (int n = 0; n < 50 && txr !== 1'b1; n++) @(negedge clock);
    @(posedge clock);
    #1 txd = d;
    txv = 1'b1;
    @(posedge clock);
    #1 txv = 1'b0;
  endtask
  task pull(input logic [7:0] e);
    for (int n = 0; n < 400 && rxv !== 1'b1; n++) @(negedge clock);
    chk({rxv, rxd}, {1'b1, e}, "rx byte");
    @(posedge clock);
    #1 rxr = 1'b1;
    @(posedge clock);
    #1 rxr = 1'b0;
  endtask
  // ====
  // Scenarios
  task t_target;
    chk(mtu, `SESL_MTU_BYTES, "mtu");
    chk({sclk_oe_n, cs_oe_n, attn_n}, 3'b111, "idle pins");
    push(8'ha5);
    chk(attn_n, 1'b0, "attention");
    i_sesl_host_model.xfer(8'h3c, r);
    chk(r, 8'ha5, "miso byte");
    pull(8'h3c);
    chk(sel_n, 16'h0001, "select event");
    chk(dsel_n, 16'h0001, "deselect event");
    $display("test target done");
  endtask
  task t_overrun;
    i_sesl_host_model.xfer(8'h5a, r);
    i_sesl_host_model.xfer(8'hc3, r);
    chk(r, `SESL_POLL_BYTE, "poll byte");
    chk({rxv, rxd, ovr}, {1'b1, 8'h5a, 1'b1}, "overrun");
    pull(8'h5a);
    $display("test overrun done");
  endtask
  task t_suspend;
    @(posedge clock);
    #1 susp = 1'b1;
    i_sesl_host_model.xfer(8'h77, r);
    chk(rxv, 1'b0, "suspended");
    @(posedge clock);
    #1 susp = 1'b0;
    i_sesl_host_model.xfer(8'h81, r);
    pull(8'h81);
    $display("test suspend done");
  endtask
  task t_master;
    @(posedge clock);
    #1 mst = 1'b1;
    r0 = rises;
    start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
    chk(cs_oe_n, 1'b0, "master select");
    chk({cs_o, lact}, 2'b01, "master busy");
    pull(8'hff);
    chk(rises - r0, 16'h0008, "eight clocks");
    $display("test master done");
  endtask
  // Watchdog
  initial begin
    #400000;
    fail_count++;
    stop_test;
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    #1 reset_n = 1'b1;
    en = 1'b1;
    @(posedge clock);
    t_target;
    t_overrun;
    t_suspend;
    t_master;
    stop_test;
  end
endmodule // sesl_link_test
`default_nettype wire
